// *** src/gpcp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpcp_top
    import gpcp_pkg::*;
(
    // Clock, power-on reset and the other (pin or brown-out) reset request.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              other_reset_req,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Port A pads.
    input  wire logic [PORT_W-1:0] port_a_pad_in,
    output logic      [PORT_W-1:0] port_a_pad_out,
    output logic      [PORT_W-1:0] port_a_pad_oe,
    // Port B pads and weak pull-up controls.
    input  wire logic [PORT_W-1:0] port_b_pad_in,
    output logic      [PORT_W-1:0] port_b_pad_out,
    output logic      [PORT_W-1:0] port_b_pad_oe,
    output logic      [PORT_W-1:0] port_b_pullup,
    // Peripheral inputs taken from port A and the wake request.
    output logic                   timer_zero_clock_input,
    output logic                   slave_select_in,
    output logic                   wake_req
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [PORT_W-1:0] pa_lat;
        logic [PORT_W-1:0] pa_dir;
        logic [PORT_W-1:0] pa_ans;
        logic [PORT_W-1:0] pa_oe;
        logic [PORT_W-1:0] pb_lat;
        logic [PORT_W-1:0] pb_dir;
        logic [PORT_W-1:0] pb_ans;
        logic [PORT_W-1:0] pb_oe;
        logic [PORT_W-1:0] pb_wpu;
        logic [PORT_W-1:0] pb_ioc;
        logic [PORT_W-1:0] pb_pull;
        logic [PORT_W-1:0] snap;
        logic [7:0]        option;
        logic [7:0]        intctl;
        logic [7:0]        altsel;
        logic              wr_act;
        logic [ADDR_W-1:0] wr_addr;
        logic [31:0]       rdata;
        logic              rdy;
        logic              resp;
        logic              wake;
        logic              t0;
        logic              ss;
    } gpcp_state_t;

    localparam gpcp_state_t ST_RST = '{
        pa_lat:  RST_LATCH,
        pa_dir:  RST_DIR,
        pa_ans:  RST_ANS,
        pa_oe:   ~RST_DIR,
        pb_lat:  RST_LATCH,
        pb_dir:  RST_DIR,
        pb_ans:  RST_ANS,
        pb_oe:   ~RST_DIR,
        pb_wpu:  RST_WPU,
        pb_ioc:  RST_IOC,
        pb_pull: 8'h00,
        snap:    RST_SNAP,
        option:  RST_OPTION,
        intctl:  RST_INTCTL,
        altsel:  RST_ALTSEL,
        wr_act:  1'b0,
        wr_addr: 8'h00,
        rdata:   32'h0000_0000,
        rdy:     1'b1,
        resp:    1'b0,
        wake:    1'b0,
        t0:      1'b0,
        ss:      1'b0
    };

    gpcp_state_t       st_r;
    gpcp_state_t       st_nxt;
    logic [PORT_W-1:0] pa_s;
    logic [PORT_W-1:0] pb_s;
    logic [PORT_W-1:0] b_dig;
    logic [PORT_W-1:0] b_rd_val;
    logic [PORT_W-1:0] mism;
    logic              acc;
    logic [7:0]        rd_byte;

    // ****************************************************************
    // Pad synchronisers
    // ****************************************************************
    // Both ports pass two flip-flops before any logic looks at them.
    gpcp_sync #(
        .WIDTH (2 * PORT_W)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({port_b_pad_in, port_a_pad_in}),
        .q     ({pb_s, pa_s})
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Register writes, reads with their side effects, and pin control.
    always_comb begin
        st_nxt = st_r;
        // Digital input buffers are off on analog pins, so they read zero.
        b_dig = pb_s & ~st_r.pb_ans;
        // Mismatch against the snapshot that stood before this cycle.
        mism = (b_dig ^ st_r.snap) & st_r.pb_ioc;
        acc = hsel & htrans[1] & hready;

        // Data phase of a write; the low byte replaces the register, masked to implemented bits for INTCTL and ALTSEL.
        if (st_r.wr_act) begin
            unique case (st_r.wr_addr)
                OFF_PA_DATA: st_nxt.pa_lat = hwdata[7:0];
                OFF_PA_DIR:  st_nxt.pa_dir = hwdata[7:0];
                OFF_PA_ANS:  st_nxt.pa_ans = hwdata[7:0];
                OFF_PB_DATA: begin
                    st_nxt.pb_lat = hwdata[7:0];
                    st_nxt.snap   = b_dig;
                end
                OFF_PB_DIR:  st_nxt.pb_dir = hwdata[7:0];
                OFF_PB_ANS:  st_nxt.pb_ans = hwdata[7:0];
                OFF_PB_WPU:  st_nxt.pb_wpu = hwdata[7:0];
                OFF_PB_IOC:  st_nxt.pb_ioc = hwdata[7:0];
                OFF_OPTION:  st_nxt.option = hwdata[7:0];
                OFF_INTCTL:  st_nxt.intctl = hwdata[7:0] & INTCTL_MASK;
                OFF_ALTSEL:  st_nxt.altsel = hwdata[7:0] & ALTSEL_MASK;
                default: ;
            endcase
        end

        // Read value of port B as seen with this cycle's settings applied.
        b_rd_val = pb_s & ~st_nxt.pb_ans;
        unique case (haddr[ADDR_W-1:0])
            OFF_PA_DATA: rd_byte = pa_s & ~st_nxt.pa_ans;
            OFF_PA_DIR:  rd_byte = st_nxt.pa_dir;
            OFF_PA_ANS:  rd_byte = st_nxt.pa_ans;
            OFF_PB_DATA: rd_byte = b_rd_val;
            OFF_PB_DIR:  rd_byte = st_nxt.pb_dir;
            OFF_PB_ANS:  rd_byte = st_nxt.pb_ans;
            OFF_PB_WPU:  rd_byte = st_nxt.pb_wpu;
            OFF_PB_IOC:  rd_byte = st_nxt.pb_ioc;
            OFF_OPTION:  rd_byte = st_nxt.option;
            OFF_INTCTL:  rd_byte = st_nxt.intctl;
            OFF_ALTSEL:  rd_byte = st_nxt.altsel;
            default:     rd_byte = 8'h00;
        endcase

        // Address phase: capture writes, answer reads one cycle later.
        st_nxt.wr_act  = acc & hwrite;
        st_nxt.wr_addr = haddr[ADDR_W-1:0];
        if (acc && !hwrite) begin
            st_nxt.rdata = {24'h00_0000, rd_byte};
            if (haddr[ADDR_W-1:0] == OFF_PB_DATA) begin
                st_nxt.snap = b_dig;
            end
        end

        // A mismatch sets the flag even while software clears it.
        if (|mism) begin
            st_nxt.intctl[CHG_FLAG_BIT] = 1'b1;
        end

        // Drivers follow direction bits only, analog or not.
        st_nxt.pa_oe = ~st_nxt.pa_dir;
        st_nxt.pb_oe = ~st_nxt.pb_dir;
        // Pull-up on only for inputs with the global disable clear.
        st_nxt.pb_pull = st_nxt.pb_wpu & st_nxt.pb_dir
                       & {PORT_W{~st_nxt.option[GPD_BIT]}};
        st_nxt.wake = st_nxt.intctl[CHG_FLAG_BIT]
                    & st_nxt.intctl[CHG_EN_BIT];
        // Peripheral inputs take the pad itself, whatever the direction.
        st_nxt.t0 = pa_s[T0_PIN];
        st_nxt.ss = st_nxt.altsel[SS_SEL_BIT] ? pa_s[SS_PIN_ALT]
                                              : pa_s[SS_PIN_MAIN];
        st_nxt.rdy  = 1'b1;
        st_nxt.resp = 1'b0;

        // Pin or brown-out reset restores all but the snapshot.
        if (other_reset_req) begin
            st_nxt      = ST_RST;
            st_nxt.snap = st_r.snap;
        end
    end

    // State register; only power-on reset clears the snapshot.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign hrdata                 = st_r.rdata;
    assign hreadyout              = st_r.rdy;
    assign hresp                  = st_r.resp;
    assign port_a_pad_out         = st_r.pa_lat;
    assign port_a_pad_oe          = st_r.pa_oe;
    assign port_b_pad_out         = st_r.pb_lat;
    assign port_b_pad_oe          = st_r.pb_oe;
    assign port_b_pullup          = st_r.pb_pull;
    assign timer_zero_clock_input = st_r.t0;
    assign slave_select_in        = st_r.ss;
    assign wake_req               = st_r.wake;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A direction write reaches the driver enables one edge later.
    a_dir_drives: assert property (
        (st_r.wr_act && st_r.wr_addr == OFF_PB_DIR && !other_reset_req)
        |=> (port_b_pad_oe == ~$past(hwdata[7:0])))
        else $error("port B enable does not follow direction write");

    // An analog output pin still drives the written latch value.
    a_latch_write: assert property (
        (st_r.wr_act && st_r.wr_addr == OFF_PA_DATA && !other_reset_req)
        |=> (port_a_pad_out == $past(hwdata[7:0])))
        else $error("port A latch does not take written value");

    // A port B read returns pins with analog bits forced to zero.
    a_read_pins: assert property (
        (acc && !hwrite && haddr[7:0] == OFF_PB_DATA && !other_reset_req)
        |=> (hrdata == {24'h00_0000, $past(b_rd_val)})
            && ((hrdata[7:0] & $past(st_nxt.pb_ans)) == 8'h00))
        else $error("port B read value wrong");

    // No pull-up on a driven pin.
    a_pull_output: assert property (
        (port_b_pullup & port_b_pad_oe) == 8'h00)
        else $error("pull-up active on output pin");

    // The global disable turns every pull-up off.
    a_pull_global: assert property (
        (|port_b_pullup) |-> !st_r.option[GPD_BIT])
        else $error("pull-up active while globally disabled");

    // A mismatch sets the change flag at the next edge.
    a_flag_set: assert property (
        ((|mism) && !other_reset_req) |=> st_r.intctl[CHG_FLAG_BIT])
        else $error("mismatch did not set change flag");

    // A change during a port B read is not lost.
    a_read_race: assert property (
        (acc && !hwrite && haddr[7:0] == OFF_PB_DATA && (|mism) && !other_reset_req)
        |=> st_r.intctl[CHG_FLAG_BIT] ##0 (st_r.snap == $past(b_dig)))
        else $error("change lost during port read");

    // Wake request follows the enabled flag.
    a_wake_req: assert property (
        (st_r.intctl[CHG_FLAG_BIT] && st_r.intctl[CHG_EN_BIT]) == wake_req)
        else $error("wake request mismatch");

    // The other reset keeps the snapshot.
    a_snap_keep: assert property (
        other_reset_req |=> $stable(st_r.snap))
        else $error("snapshot lost on other reset");

    // The timer input and slave select follow the synchronised pads.
    a_timer_pad: assert property (
        ##1 (timer_zero_clock_input == $past(pa_s[T0_PIN]) || $past(other_reset_req)))
        else $error("timer input does not follow pad");

    a_ss_route: assert property (
        !other_reset_req |=> (slave_select_in == ($past(st_nxt.altsel[SS_SEL_BIT])
            ? $past(pa_s[SS_PIN_ALT]) : $past(pa_s[SS_PIN_MAIN]))))
        else $error("slave select routed from wrong pin");

    // Writing the analog select leaves drivers and latches alone.
    a_ans_no_drive: assert property (
        (st_r.wr_act && st_r.wr_addr == OFF_PB_ANS && !other_reset_req)
        |=> ($stable(port_b_pad_oe) && $stable(port_b_pad_out)))
        else $error("analog select write disturbed port B drivers");

    // A write to port B also refreshes the snapshot.
    a_write_snap: assert property (
        (st_r.wr_act && st_r.wr_addr == OFF_PB_DATA && !other_reset_req)
        |=> (st_r.snap == $past(b_dig)))
        else $error("port B write did not refresh snapshot");

    // Without a mismatch or a register write the flag cannot rise.
    a_flag_quiet: assert property (
        (!st_r.intctl[CHG_FLAG_BIT] && !(|mism)
            && !(st_r.wr_act && st_r.wr_addr == OFF_INTCTL))
        |=> !st_r.intctl[CHG_FLAG_BIT])
        else $error("change flag set without a mismatch");

    // An enabled mismatch raises the wake request at the next edge.
    a_wake_mism: assert property (
        ((|mism) && st_nxt.intctl[CHG_EN_BIT] && !other_reset_req) |=> wake_req)
        else $error("mismatch did not raise wake request");

    // The other reset leaves every driver and pull-up off.
    a_other_rst: assert property (
        other_reset_req |=> (port_a_pad_oe == ~RST_DIR && port_b_pad_oe == ~RST_DIR
            && port_b_pullup == 8'h00))
        else $error("drivers or pull-ups on after other reset");

    // Main scenarios.
    c_flag_set:  cover property (!st_r.intctl[CHG_FLAG_BIT] ##1 st_r.intctl[CHG_FLAG_BIT]);
    c_read_race: cover property (acc && !hwrite && haddr[7:0] == OFF_PB_DATA && (|mism));
    c_pull_on:   cover property (|port_b_pullup);
    c_wake:      cover property ($rose(wake_req));

endmodule
`default_nettype wire

// *** src/gpcp_pkg.sv ***
// ****************************************************************
// Constants shared by the port block.
// ****************************************************************
package gpcp_pkg;

    // Port width and decoded address width.
    localparam int          PORT_W          = 8;
    localparam int          ADDR_W          = 8;

    // Register byte offsets on the bus.
    localparam logic [7:0]  OFF_PA_DATA     = 8'h00;
    localparam logic [7:0]  OFF_PA_DIR      = 8'h04;
    localparam logic [7:0]  OFF_PA_ANS      = 8'h08;
    localparam logic [7:0]  OFF_PB_DATA     = 8'h0C;
    localparam logic [7:0]  OFF_PB_DIR      = 8'h10;
    localparam logic [7:0]  OFF_PB_ANS      = 8'h14;
    localparam logic [7:0]  OFF_PB_WPU      = 8'h18;
    localparam logic [7:0]  OFF_PB_IOC      = 8'h1C;
    localparam logic [7:0]  OFF_OPTION      = 8'h20;
    localparam logic [7:0]  OFF_INTCTL      = 8'h24;
    localparam logic [7:0]  OFF_ALTSEL      = 8'h28;

    // Field positions.
    localparam int          GPD_BIT         = 7;
    localparam int          CHG_FLAG_BIT    = 0;
    localparam int          CHG_EN_BIT      = 3;
    localparam int          SS_SEL_BIT      = 1;
    localparam int          T0_PIN          = 4;
    localparam int          SS_PIN_MAIN     = 5;
    localparam int          SS_PIN_ALT      = 0;

    // Implemented-bit masks.
    localparam logic [7:0]  INTCTL_MASK     = 8'h09;
    localparam logic [7:0]  ALTSEL_MASK     = 8'h02;

    // Reset values.
    localparam logic [7:0]  RST_LATCH       = 8'h00;
    localparam logic [7:0]  RST_DIR         = 8'hFF;
    localparam logic [7:0]  RST_ANS         = 8'hFF;
    localparam logic [7:0]  RST_WPU         = 8'hFF;
    localparam logic [7:0]  RST_IOC         = 8'h00;
    localparam logic [7:0]  RST_OPTION      = 8'hFF;
    localparam logic [7:0]  RST_INTCTL      = 8'h00;
    localparam logic [7:0]  RST_ALTSEL      = 8'h00;
    localparam logic [7:0]  RST_SNAP        = 8'h00;

endpackage

// *** src/gpcp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for pad inputs.
// ****************************************************************
module gpcp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Asynchronous input and its synchronised copy.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } gpcp_sync_t;

    gpcp_sync_t st_r;
    gpcp_sync_t st_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule
`default_nettype wire

// *** sim/gpcp_pads.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Outside circuitry on one port: a source, pull-ups and open lines.
// ****************************************************************
module gpcp_pads (
    // Clock for the pattern on undriven lines.
    input  wire logic       clk,
    // Device side of each pin.
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pull_en,
    // Outside source and its per-pin enables.
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // Resolved pin level.
    output logic      [7:0] pad
);
    logic [7:0] flt_r = 8'h5A;

    // An undriven line wanders, so a stale level is never read back.
    always @(posedge clk) begin
        flt_r <= ~flt_r;
    end

    // The outside source yields to the device driver; pull-ups act last.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
                   : pull_en[i] ? 1'b1 : flt_r[i];
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
// ****************************************************************
// Self-checking bench for the two ports.
// ****************************************************************
module tb
    import gpcp_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, other_reset_req = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, rd_ph = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, exp_v, rnd = 32'h159A81FF;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pb_pu, a, dr, d;
    logic [7:0]  pa_ext = 8'hFF, pb_ext = 8'hFF;
    logic        tmr, ss, wake;
    logic [31:0] q[$];
    int          fail_count = 0, checked = 0;
    logic [7:0]  offs[12] = '{OFF_PA_DATA, OFF_PA_DIR, OFF_PA_ANS, OFF_PB_DATA, OFF_PB_DIR,
        OFF_PB_ANS, OFF_PB_WPU, OFF_PB_IOC, OFF_OPTION, OFF_INTCTL, OFF_ALTSEL, 8'h2C};
    logic [7:0]  rstv[12] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF,
        8'h00, 8'h00, 8'h00};

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    // Clock of 20 ns.
    always #10 hclk = ~hclk;

    gpcp_top dut (.hclk(hclk), .hresetn(hresetn), .other_reset_req(other_reset_req),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .port_a_pad_in(pa_in), .port_a_pad_out(pa_out),
        .port_a_pad_oe(pa_oe), .port_b_pad_in(pb_in), .port_b_pad_out(pb_out),
        .port_b_pad_oe(pb_oe), .port_b_pullup(pb_pu), .timer_zero_clock_input(tmr),
        .slave_select_in(ss), .wake_req(wake));
    gpcp_pads pads_a (.clk(hclk), .pad_out(pa_out), .pad_oe(pa_oe), .pull_en(8'h00),
        .ext_val(pa_ext), .ext_en(8'hFF), .pad(pa_in));
    gpcp_pads pads_b (.clk(hclk), .pad_out(pb_out), .pad_oe(pb_oe), .pull_en(pb_pu),
        .ext_val(pb_ext), .ext_en(8'hFF), .pad(pb_in));

    // Takes the oldest noted read result whenever a read data phase ends.
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1 && q.size() > 0) begin
            exp_v = q.pop_front();
            `CHK(hrdata, exp_v)
            `CHK(hresp, 1'b0)
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hready;
    end

    // Next value of the pseudo-random sequence.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        // Noted reads that were never compared count as one mismatch in all.
        if (q.size() != 0) begin
            fail_count++;
        end
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Waits for an edge with ready high, giving up after 50 edges.
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic [7:0] ad, input logic w, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, ad};
        hwrite <= w;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        edge_ready();
    endtask

    // Register write.
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        bus(ad, 1'b1, wd);
    endtask

    // Register read, noting the expected word first.
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        q.push_back({24'h000000, e});
        bus(ad, 1'b0, 8'h00);
    endtask

    // Waits a bounded time for the wake request to reach a level.
    task automatic wait_wake(input logic v);
        for (int i = 0; i < 10 && wake !== v; i++) begin
            @(posedge hclk);
        end
        `CHK(wake, v)
        if (wake !== v) begin
            final_report();
        end
    endtask

    // Main sequence.
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK(pb_oe, 8'h00)
        `CHK(pb_pu, 8'h00)
        for (int i = 0; i < 12; i++) begin
            rd(offs[i], rstv[i]);
        end
        // Random direction, analog select, latch and outside levels.
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            a = rnd[7:0];
            dr = rnd[15:8];
            d = rnd[23:16];
            pb_ext <= rnd[31:24];
            wr(OFF_PB_ANS, a);
            wr(OFF_PB_DIR, dr);
            wr(OFF_PB_DATA, d);
            repeat (4) @(posedge hclk);
            `CHK(pb_oe, ~dr)
            `CHK(pb_out, d)
            rd(OFF_PB_DATA, ((d & ~dr) | (pb_ext & dr)) & ~a);
        end
        // Pull-ups under the global disable and the direction bits.
        rnd = lfsr(rnd);
        wr(OFF_OPTION, 8'h7F);
        wr(OFF_PB_WPU, rnd[7:0]);
        repeat (2) @(posedge hclk);
        `CHK(pb_pu, rnd[7:0] & dr)
        wr(OFF_OPTION, 8'hFF);
        repeat (2) @(posedge hclk);
        `CHK(pb_pu, 8'h00)
        // Change detection on bit 0 only; software keeps all pins as digital inputs.
        wr(OFF_PB_DIR, 8'hFF);
        wr(OFF_PB_ANS, 8'h00);
        pb_ext <= 8'h00;
        repeat (4) @(posedge hclk);
        rd(OFF_PB_DATA, 8'h00);
        wr(OFF_PB_IOC, 8'h01);
        wr(OFF_INTCTL, 8'h08);
        pb_ext <= 8'h02;
        repeat (6) @(posedge hclk);
        rd(OFF_INTCTL, 8'h08);
        pb_ext <= 8'h03;
        wait_wake(1'b1);
        rd(OFF_INTCTL, 8'h09);
        wr(OFF_INTCTL, 8'h08);
        rd(OFF_INTCTL, 8'h09);
        rd(OFF_PB_DATA, 8'h03);
        wr(OFF_INTCTL, 8'h08);
        rd(OFF_INTCTL, 8'h08);
        wait_wake(1'b0);
        // Snapshot of 1 on bit 0 kept through the other reset.
        pb_ext <= 8'h02;
        other_reset_req <= 1'b1;
        @(posedge hclk);
        other_reset_req <= 1'b0;
        @(posedge hclk);
        rd(OFF_PB_IOC, 8'h00);
        wr(OFF_PB_ANS, 8'h00);
        wr(OFF_PB_IOC, 8'h01);
        repeat (4) @(posedge hclk);
        rd(OFF_INTCTL, 8'h01);
        // Timer input and slave select taken from port A.
        pa_ext <= 8'h20;
        wr(OFF_PA_DIR, 8'hEF);
        wr(OFF_PA_DATA, 8'h10);
        repeat (4) @(posedge hclk);
        `CHK(pa_oe, 8'h10)
        `CHK(pa_out, 8'h10)
        `CHK(tmr, 1'b1)
        `CHK(ss, 1'b1)
        wr(OFF_PA_DATA, 8'h00);
        wr(OFF_ALTSEL, 8'hFF);
        repeat (4) @(posedge hclk);
        `CHK(tmr, 1'b0)
        `CHK(ss, 1'b0)
        rd(OFF_ALTSEL, 8'h02);
        pa_ext <= 8'h2F;
        wr(OFF_PA_ANS, 8'h0F);
        rd(OFF_PA_DATA, 8'h20);
        repeat (3) @(posedge hclk);
        final_report();
    end
endmodule
`default_nettype wire
